// >>> idma_core.v
/*
  data-memory decode with three indirect ports, five pointers and general RAM.
  assumes the core presents address, strobes and write data for a single cycle;
  read data is combinational in that cycle, writes land at the clock edge.
  a read and a write in one cycle are allowed: the read sees the old value.
  ports answer only at their sector 0 offsets; elsewhere those offsets are ordinary.
  the ram index is sized for at most four sectors; more needs a wider index.
  peripheral special registers live outside: their select and data come via sfr_* ports.
*/
// Summary of operation
// - reads of unused special locations return 00H.
// - in each sector 00H-7FH is special area; in sectors below SECTORS 80H-FFH is RAM.
// - indirect port access goes to the pointer-named location, not the port.
// - first port with its pointer always targets sector 0.
// - second and third ports reach any sector from their sector pointer.
// - low pointer gives address within the chosen sector.
// - port addressed via a pointer reads 00H, write does nothing.
// - all five pointers are real read/write 8-bit storage.
// - direct access reaches every sector without pointers.
// - direct address is 11 bits: high part sector, low byte location.
// - special register decode depends on selected sector.
// - protected special registers ignore software writes.
// - reserved special locations keep contents when written.
`timescale 1ns/1ns
`include "idma_map.vh"

module idma_core #(
  parameter SECTORS = 4
) (
  input  wire                    core_clk_i,
  input  wire                    nrst_i,
  input  wire [`IDMA_ADDR_W-1:0] addr_i,
  input  wire                    rd_i,
  input  wire                    wr_i,
  input  wire [7:0]              wdata_i,
  output reg  [7:0]              rdata_o,
  output wire [`IDMA_ADDR_W-1:0] sfr_addr_o,
  output wire                    sfr_rd_o,
  output wire                    sfr_wr_o,
  output wire [7:0]              sfr_wdata_o,
  input  wire                    sfr_hit_i,
  input  wire                    sfr_wprot_i,
  input  wire [7:0]              sfr_rdata_i
);

  localparam [`IDMA_SEC_W-1:0] SEC_ZERO  = 3'h0;
  localparam                   RAM_WORDS = SECTORS * 128;

  // read source, one-hot
  localparam [7:0] SRC_ZERO = 8'h01;
  localparam [7:0] SRC_RAM  = 8'h02;
  localparam [7:0] SRC_PTR0 = 8'h04;
  localparam [7:0] SRC_PAL  = 8'h08;
  localparam [7:0] SRC_PAS  = 8'h10;
  localparam [7:0] SRC_PBL  = 8'h20;
  localparam [7:0] SRC_PBS  = 8'h40;
  localparam [7:0] SRC_SFR  = 8'h80;

  wire [7:0] ptr0_q;
  wire [7:0] ptra_lo_q;
  wire [7:0] ptra_sec_q;
  wire [7:0] ptrb_lo_q;
  wire [7:0] ptrb_sec_q;
  reg  [7:0] ram_q [0:RAM_WORDS-1];

  wire [`IDMA_SEC_W-1:0] dir_sec = addr_i[`IDMA_ADDR_W-1:8];
  wire [7:0]             dir_ofs = addr_i[7:0];

  wire hit_p0 = (dir_sec == SEC_ZERO) && (dir_ofs == `IDMA_OFS_PORT0);
  wire hit_pa = (dir_sec == SEC_ZERO) && (dir_ofs == `IDMA_OFS_PORTA);
  wire hit_pb = (dir_sec == SEC_ZERO) && (dir_ofs == `IDMA_OFS_PORTB);

  // only the low sector bits steer; the upper bits of a sector pointer are storage only
  wire [`IDMA_SEC_W-1:0] pa_sec = ptra_sec_q[`IDMA_SEC_W-1:0];
  wire [`IDMA_SEC_W-1:0] pb_sec = ptrb_sec_q[`IDMA_SEC_W-1:0];

  // pointer sampled in the access cycle
  // no pipeline: an increment of a pointer is seen by the very next indirect access
  reg  [`IDMA_ADDR_W-1:0] eff_addr;
  always @* begin
    if (hit_p0) begin
      eff_addr = {SEC_ZERO, ptr0_q};
    end else if (hit_pa) begin
      eff_addr = {pa_sec, ptra_lo_q};
    end else if (hit_pb) begin
      eff_addr = {pb_sec, ptrb_lo_q};
    end else begin
      eff_addr = addr_i;
    end
  end

  wire [`IDMA_SEC_W-1:0] eff_sec = eff_addr[`IDMA_ADDR_W-1:8];
  wire [7:0]             eff_ofs = eff_addr[7:0];

  // upper half of each sector below SECTORS is RAM
  wire is_gpr  = eff_ofs[`IDMA_GPR_BIT];
  // the upper half of sectors past the fitted ram reads zero and drops writes
  wire sec_ok  = ({5'h00, eff_sec} < SECTORS);
  wire is_ram  = is_gpr && sec_ok;
  // limitation: two sector bits in the index, so at most four sectors
  wire [8:0] ram_idx = {eff_sec[1:0], eff_ofs[6:0]};

  // a port reached through a pointer behaves as nothing
  wire tgt_sec0 = (eff_sec == SEC_ZERO) && !is_gpr;
  wire tgt_p0   = tgt_sec0 && (eff_ofs == `IDMA_OFS_PORT0);
  wire tgt_pa   = tgt_sec0 && (eff_ofs == `IDMA_OFS_PORTA);
  wire tgt_pb   = tgt_sec0 && (eff_ofs == `IDMA_OFS_PORTB);
  wire tgt_port = tgt_p0 | tgt_pa | tgt_pb;

  wire hit_ptr0 = tgt_sec0 && (eff_ofs == `IDMA_OFS_PTR0);
  wire hit_pal  = tgt_sec0 && (eff_ofs == `IDMA_OFS_PTRA_LO);
  wire hit_pas  = tgt_sec0 && (eff_ofs == `IDMA_OFS_PTRA_SEC);
  wire hit_pbl  = tgt_sec0 && (eff_ofs == `IDMA_OFS_PTRB_LO);
  wire hit_pbs  = tgt_sec0 && (eff_ofs == `IDMA_OFS_PTRB_SEC);
  wire hit_ptr  = hit_ptr0 | hit_pal | hit_pas | hit_pbl | hit_pbs;

  // peripheral decode sees the resolved sector and offset
  wire to_sfr = !is_gpr && !tgt_port && !hit_ptr;
  assign sfr_addr_o  = eff_addr;
  assign sfr_rd_o    = rd_i && to_sfr;
  assign sfr_wdata_o = wdata_i;

  // write steering: a port itself stores nothing
  reg we_ptr0;
  reg we_pal;
  reg we_pas;
  reg we_pbl;
  reg we_pbs;
  reg we_ram;
  reg we_sfr;
  always @* begin
    we_ptr0 = 1'b0;
    we_pal  = 1'b0;
    we_pas  = 1'b0;
    we_pbl  = 1'b0;
    we_pbs  = 1'b0;
    we_ram  = 1'b0;
    we_sfr  = 1'b0;
    if (wr_i) begin
      we_ptr0 = hit_ptr0;
      we_pal  = hit_pal;
      we_pas  = hit_pas;
      we_pbl  = hit_pbl;
      we_pbs  = hit_pbs;
      we_ram  = is_ram;
      // protected and reserved locations never see a write
      we_sfr  = to_sfr && sfr_hit_i && !sfr_wprot_i;
    end
  end

  assign sfr_wr_o = we_sfr;

  // read source select; anything unclaimed falls to zero
  reg [7:0] rd_src;
  always @* begin
    rd_src = SRC_ZERO;
    if (rd_i) begin
      if (is_ram) begin
        rd_src = SRC_RAM;
      end else if (hit_ptr0) begin
        rd_src = SRC_PTR0;
      end else if (hit_pal) begin
        rd_src = SRC_PAL;
      end else if (hit_pas) begin
        rd_src = SRC_PAS;
      end else if (hit_pbl) begin
        rd_src = SRC_PBL;
      end else if (hit_pbs) begin
        rd_src = SRC_PBS;
      end else if (to_sfr && sfr_hit_i) begin
        rd_src = SRC_SFR;
      end else begin
        rd_src = SRC_ZERO;
      end
    end
  end

  always @* begin
    case (rd_src)
      SRC_RAM: begin
        rdata_o = ram_q[ram_idx];
      end
      SRC_PTR0: begin
        rdata_o = ptr0_q;
      end
      SRC_PAL: begin
        rdata_o = ptra_lo_q;
      end
      SRC_PAS: begin
        rdata_o = ptra_sec_q;
      end
      SRC_PBL: begin
        rdata_o = ptrb_lo_q;
      end
      SRC_PBS: begin
        rdata_o = ptrb_sec_q;
      end
      SRC_SFR: begin
        rdata_o = sfr_rdata_i;
      end
      default: begin
        rdata_o = `IDMA_READ_ZERO;
      end
    endcase
  end

  // pointers are ordinary read-modify-write storage
  // sector 0 pointer
  idma_ptr_reg #(
    .WIDTH (8),
    .RST   (`IDMA_PTR_RST)
  ) ptr0_u (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .we_i       (we_ptr0),
    .wdata_i    (wdata_i),
    .q_o        (ptr0_q)
  );

  // second port, location within sector
  idma_ptr_reg #(
    .WIDTH (8),
    .RST   (`IDMA_PTR_RST)
  ) ptra_lo_u (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .we_i       (we_pal),
    .wdata_i    (wdata_i),
    .q_o        (ptra_lo_q)
  );

  // second port, sector
  idma_ptr_reg #(
    .WIDTH (8),
    .RST   (`IDMA_PTR_RST)
  ) ptra_sec_u (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .we_i       (we_pas),
    .wdata_i    (wdata_i),
    .q_o        (ptra_sec_q)
  );

  // third port, location within sector
  idma_ptr_reg #(
    .WIDTH (8),
    .RST   (`IDMA_PTR_RST)
  ) ptrb_lo_u (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .we_i       (we_pbl),
    .wdata_i    (wdata_i),
    .q_o        (ptrb_lo_q)
  );

  // third port, sector
  idma_ptr_reg #(
    .WIDTH (8),
    .RST   (`IDMA_PTR_RST)
  ) ptrb_sec_u (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .we_i       (we_pbs),
    .wdata_i    (wdata_i),
    .q_o        (ptrb_sec_q)
  );

  // ram has no reset: contents are undefined at power-up, as for real sram
  // writes to the upper half of a missing sector are already dropped by we_ram
  always @(posedge core_clk_i) begin
    if (we_ram) begin
      ram_q[ram_idx] <= wdata_i;
    end
  end

endmodule // idma_core

// one pointer byte: plain storage written by direct or indirect access;
// kept separate so every pointer resets and loads the same way
module idma_ptr_reg #(
  parameter             WIDTH = 8,
  parameter [WIDTH-1:0] RST   = {WIDTH{1'b0}}
) (
  input  wire             core_clk_i,
  input  wire             nrst_i,
  input  wire             we_i,
  input  wire [WIDTH-1:0] wdata_i,
  output reg  [WIDTH-1:0] q_o
);

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= RST;
    end else if (we_i) begin
      q_o <= wdata_i;
    end
  end

endmodule // idma_ptr_reg

// >>> idma_map.vh
/*
  register map and decode constants for the indirect data memory access block.
  assumes an 8-bit core issuing one data-memory access per cycle with an 11-bit address.
*/
`ifndef IDMA_MAP_VH
`define IDMA_MAP_VH

`define IDMA_OFS_PORT0      8'h00
`define IDMA_OFS_PTR0       8'h01
`define IDMA_OFS_PORTA      8'h02
`define IDMA_OFS_PTRA_LO    8'h03
`define IDMA_OFS_PTRA_SEC   8'h04
`define IDMA_OFS_PORTB      8'h0C
`define IDMA_OFS_PTRB_LO    8'h0D
`define IDMA_OFS_PTRB_SEC   8'h0E

`define IDMA_GPR_BIT        7
`define IDMA_ADDR_W         11
`define IDMA_SEC_W          3
`define IDMA_PTR_RST        8'h00
`define IDMA_READ_ZERO      8'h00

`endif

// >>> idma_periph.sv
/* peripheral register model; assumes idma_core drives the sfr_* side */
`timescale 1ns/1ns
module idma_periph (
  input  wire        core_clk_i,
  input  wire [10:0] sfr_addr_o,
  input  wire        sfr_wr_o,
  input  wire [7:0]  sfr_wdata_o,
  output wire        sfr_hit_i,
  output wire        sfr_wprot_i,
  output wire [7:0]  sfr_rdata_i
);
  reg [7:0] reg_q;
  assign sfr_hit_i = sfr_addr_o == 11'h010 || sfr_addr_o == 11'h12C;
  assign sfr_wprot_i = sfr_addr_o == 11'h12C;
  // unselected bus floats high so a leak shows
  assign sfr_rdata_i = !sfr_hit_i ? 8'hFF : sfr_wprot_i ? 8'hA5 : reg_q;
  always @(posedge core_clk_i) if (sfr_wr_o) reg_q <= sfr_wdata_o;
endmodule // idma_periph

// >>> idma_properties.sv
/* port checker for idma_core; assumes it is bound onto every instance */
`timescale 1ns/1ns
module idma_chk (
  input wire        core_clk_i,
  input wire        nrst_i,
  input wire [10:0] addr_i,
  input wire        rd_i,
  input wire        wr_i,
  input wire [7:0]  wdata_i,
  input wire [7:0]  rdata_o,
  input wire [10:0] sfr_addr_o,
  input wire        sfr_rd_o,
  input wire        sfr_wr_o,
  input wire        sfr_hit_i,
  input wire        sfr_wprot_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_unused_zero: assert property (rd_i && addr_i == 11'h00B && !sfr_hit_i |-> rdata_o == 8'h00) else $error("unused");
  a_wr_guard: assert property (sfr_wr_o |-> wr_i && sfr_hit_i && !sfr_wprot_i) else $error("wr guard");
  a_ram_no_sfr: assert property (sfr_rd_o || sfr_wr_o |-> !sfr_addr_o[7]) else $error("ram strobe");
  a_sec0_port: assert property (rd_i && addr_i == 11'h000 |-> sfr_addr_o[10:8] == 3'h0) else $error("sector");
  a_direct_map: assert property (rd_i && addr_i[7:0] > 8'h0E |-> sfr_addr_o == addr_i) else $error("direct");
  a_ptr_rdback: assert property (wr_i && addr_i == 11'h001 ##1 rd_i && addr_i == 11'h001 |->
    rdata_o == $past(wdata_i)) else $error("pointer");
  a_ptr_route: assert property (wr_i && addr_i == 11'h003 ##1 rd_i && addr_i == 11'h002 |->
    sfr_addr_o[7:0] == $past(wdata_i)) else $error("route");
  a_port_self: assert property (rd_i && addr_i == 11'h000 && sfr_addr_o == 11'h002 |-> rdata_o == 8'h00) else $error("self");
  c_port_a: cover property (rd_i && addr_i == 11'h002);
  c_sfr_wr: cover property (sfr_wr_o);
  c_sec3: cover property (rd_i && addr_i[10:8] == 3'h3);
endmodule // idma_chk
bind idma_core idma_chk chk_u (.*);

// >>> indirect_data_memory_access_test.sv
/* self-checking bench for idma_core; assumes idma_periph on the sfr side */
`timescale 1ns/1ns
module indirect_data_memory_access_test;
  reg         core_clk_i = 0, nrst_i = 0, rd_i = 0, wr_i = 0;
  reg  [10:0] addr_i = 0;
  reg  [7:0]  wdata_i = 0;
  wire [7:0]  rdata_o, sfr_wdata_o, sfr_rdata_i;
  wire [10:0] sfr_addr_o;
  wire        sfr_rd_o, sfr_wr_o, sfr_hit_i, sfr_wprot_i;
  integer     failures = 0, comparisons = 0;
  initial forever #20 core_clk_i = ~core_clk_i;
  idma_core dut_u (.*);
  idma_periph per_u (.*);
  task chk(input [7:0] s, input [7:0] e); begin
    comparisons = comparisons + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  end endtask
  task w(input [10:0] a, input [7:0] d); begin
    @(negedge core_clk_i); addr_i = a; wdata_i = d; wr_i = 1; rd_i = 0;
  end endtask
  task r(input [10:0] a, input [7:0] e); begin
    @(negedge core_clk_i); addr_i = a; wr_i = 0; rd_i = 1;
    #10 chk(rdata_o, e);
  end endtask
  task results; begin
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  initial begin
    #80 nrst_i = 1;
    r(11'h001, 8'h00);
    w(11'h004, 8'h01); w(11'h003, 8'h80); w(11'h002, 8'h55);
    r(11'h180, 8'h55);
    chk({7'h00, sfr_rd_o}, 8'h00);
    w(11'h003, 8'h80); r(11'h002, 8'h55);
    chk(sfr_addr_o[7:0], 8'h80);
    chk({5'h00, sfr_addr_o[10:8]}, 8'h01);
    r(11'h004, 8'h01);
    $display("test 1 done");
    w(11'h001, 8'h90); w(11'h000, 8'h3C); r(11'h090, 8'h3C);
    w(11'h001, 8'h02); w(11'h000, 8'h99); r(11'h000, 8'h00);
    r(11'h002, 8'h55);
    w(11'h00E, 8'h03); w(11'h00D, 8'hF0); w(11'h00C, 8'h6B); r(11'h3F0, 8'h6B);
    $display("test 2 done");
    r(11'h00B, 8'h00);
    w(11'h010, 8'h42); #10 chk({7'h00, sfr_wr_o}, 8'h01);
    chk(sfr_wdata_o, 8'h42);
    r(11'h010, 8'h42);
    chk({7'h00, sfr_rd_o}, 8'h01);
    r(11'h110, 8'h00);
    w(11'h12C, 8'h11); #10 chk({7'h00, sfr_wr_o}, 8'h00);
    r(11'h12C, 8'hA5);
    r(11'h010, 8'h42);
    @(negedge core_clk_i); rd_i = 0;
    $display("test 3 done");
    nrst_i = 0;
    @(negedge core_clk_i); nrst_i = 1;
    r(11'h004, 8'h00);
    r(11'h3F0, 8'h6B);
    $display("test 4 done");
    results;
  end
  // whole run is about 32 cycles
  initial begin #20000 failures = failures + 1; results; end
endmodule // indirect_data_memory_access_test
